// >>> logic/ddr_phy_clock_reset_write_port.sv
// ==========================================================
// write buffer: flip-flop storage, honest full and empty
module write_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];   // storage, no reset needed
   logic [AW-1:0]    wrPtr_q;         // next slot to fill
   logic [AW-1:0]    rdPtr_q;         // oldest word
   logic [AW:0]      count_q;         // words held
   logic [AW:0]      count_d;
   logic             ready_q;         // room for one more word, a flop so ready leaves straight from it
   logic             empty_q;
   logic             push;
   logic             pop;
   assign push     = inValid & ready_q;
   assign pop      = outReady & ~empty_q;
   assign inReady  = ready_q;
   assign outValid = ~empty_q;
   assign outData  = mem_q[rdPtr_q];
   assign count_d  = count_q + (AW+1)'(push) - (AW+1)'(pop);
   // storage write
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end
   // pointers and occupancy; flags registered so ready is a flop
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         ready_q <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + AW'(1);
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + AW'(1);
         end
         count_q <= count_d;
         ready_q <= (count_d != (AW+1)'(DEPTH));
         empty_q <= (count_d == '0);
      end
   end
endmodule // write_fifo
// ==========================================================
// clock, reset and write port of the memory phy
module ddr_phy_clock_reset_write_port (
   input  wire logic                                        clk_sys,
   input  wire logic                                        rst_n,
   input  wire logic                                        pllRefClk,
   input  wire logic                                        softResetN,
   output logic                                             resetRequestN,
   output logic                                             ctlClk,
   output logic                                             ctlResetN,
   output logic                                             auxHalfRateClk,
   output logic                                             auxFullRateClk,
   output logic                                             auxScanClk,
   output logic                                             auxScanResetN,
   input  wire ddr_phy_pkg::write_word_t                    ctlWrite,
   output logic                                             ctlWriteReady,
   input  wire logic [ddr_phy_pkg::COMMAND_BITS-1:0]        controllerCommand,
   output ddr_phy_pkg::write_pins_t                         memWrite,
   output logic                                             memClk,
   output logic                                             memClkN,
   output logic                                             memClkOeN,
   input  wire logic                                        memClkIn,
   output logic                                             clockFeedbackSeen,
   output logic                                             commandParityOut,
   output logic                                             parityErrorN,
   input  wire logic                                        memErrOutN
);
   localparam int DW = ddr_phy_pkg::MEMORY_DATA_WIDTH;
   localparam int MW = ddr_phy_pkg::MEMORY_MASK_WIDTH;
   // ==========================================================
   // input synchronisers; first stage read only by the second
   logic [2:0] refSync_q;     // reference clock, third stage for edges
   logic [2:0] softSync_q;    // soft reset, third stage for edges
   logic [2:0] fbSync_q;      // memory clock feedback
   logic [1:0] errSync_q;     // parity error from the module
   logic       refRise;
   logic       softFall;
   // synchronise every pin input through two flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         refSync_q  <= '0;
         softSync_q <= 3'h7;
         fbSync_q   <= '0;
         errSync_q  <= 2'h3;
      end else begin
         refSync_q  <= {refSync_q[1:0], pllRefClk};
         softSync_q <= {softSync_q[1:0], softResetN};
         fbSync_q   <= {fbSync_q[1:0], memClkIn};
         errSync_q  <= {errSync_q[0], memErrOutN};
      end
   end
   assign refRise  = refSync_q[1] & ~refSync_q[2];
   assign softFall = softSync_q[2] & ~softSync_q[1];   // edge, not level
   // ==========================================================
   // clock generator lock model
   logic [4:0] lockEdges_q;   // reference edges seen
   logic [6:0] refIdle_q;     // cycles since last reference edge
   logic       pllLocked_q;   // lock indication, also the reset request

   // count reference edges to lock; silence drops lock.
   // global reset and reference silence clear this, never the soft reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lockEdges_q <= '0;
         refIdle_q   <= '0;
         pllLocked_q <= 1'b0;
      end else if (refIdle_q == 7'(ddr_phy_pkg::LOCK_LOSS_CYCLES - 1)) begin
         // reference gone: start acquiring again
         lockEdges_q <= '0;
         refIdle_q   <= '0;
         pllLocked_q <= 1'b0;
      end else if (refRise) begin
         refIdle_q <= '0;
         if (lockEdges_q != 5'(ddr_phy_pkg::LOCK_EDGES)) begin
            lockEdges_q <= lockEdges_q + 5'h01;
         end
         pllLocked_q <= (lockEdges_q >= 5'(ddr_phy_pkg::LOCK_EDGES - 1));
      end else begin
         refIdle_q <= refIdle_q + 7'h01;
      end
   end

   // request is the lock flop itself, low while acquiring
   assign resetRequestN = pllLocked_q;
   // ==========================================================
   // derived clocks: memory clock = sys/2, half rate = sys/4
   logic [1:0] phase_q;          // beat within the controller cycle
   logic [1:0] phaseNext;
   logic       ctlTick;          // last sys cycle before ctlClk rises
   logic       ctlClk_q;
   logic       auxHalf_q;
   logic       memClk_q;
   logic       auxFull_q;

   assign phaseNext = phase_q + 2'h1;
   assign ctlTick   = (phase_q == 2'h3);

   // both half-rate outputs share one equation so they stay identical
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_q   <= ddr_phy_pkg::PHASE_RESET;
         ctlClk_q  <= ~ddr_phy_pkg::PHASE_RESET[1];   // agrees with phase 0: no runt pulse after reset
         auxHalf_q <= ~ddr_phy_pkg::PHASE_RESET[1];
         memClk_q  <= 1'b0;
         auxFull_q <= 1'b0;
      end else begin
         phase_q   <= phaseNext;
         ctlClk_q  <= ~phaseNext[1];
         auxHalf_q <= ~phaseNext[1];
         memClk_q  <= ~phaseNext[0];
         auxFull_q <= ~phaseNext[0];
      end
   end

   assign ctlClk         = ctlClk_q;
   assign auxHalfRateClk = auxHalf_q;
   assign auxFullRateClk = auxFull_q;
   // ==========================================================
   // memory clock pins with feedback tracking
   logic memClkN_q;
   logic memClkOeN_q;
   logic fbSeen_q;

   // always driven; feedback edges mark the return path as alive
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         memClkN_q   <= 1'b1;
         memClkOeN_q <= 1'b0;
         fbSeen_q    <= 1'b0;
      end else begin
         memClkN_q   <= phaseNext[0];
         memClkOeN_q <= 1'b0;
         if (fbSync_q[1] != fbSync_q[2]) begin
            fbSeen_q <= 1'b1;
         end
      end
   end

   assign memClk            = memClk_q;
   assign memClkN           = memClkN_q;
   assign memClkOeN         = memClkOeN_q;
   assign clockFeedbackSeen = fbSeen_q;
   // ==========================================================
   // scan clock and its reset
   logic [2:0] scanDiv_q;
   logic       scanClk_q;
   logic       scanRise;
   logic       scanStage_q;
   logic       scanResetN_q;

   assign scanRise = (scanDiv_q == 3'(ddr_phy_pkg::SCAN_HALF_CYCLES - 1)) & ~scanClk_q;

   // slow divider for reconfiguration logic
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scanDiv_q <= '0;
         scanClk_q <= 1'b0;
      end else if (scanDiv_q == 3'(ddr_phy_pkg::SCAN_HALF_CYCLES - 1)) begin
         scanDiv_q <= '0;
         scanClk_q <= ~scanClk_q;
      end else begin
         scanDiv_q <= scanDiv_q + 3'h1;
      end
   end

   // cleared at once by global reset, released on scan rising edges
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scanStage_q  <= 1'b0;
         scanResetN_q <= 1'b0;
      end else if (scanRise) begin
         scanStage_q  <= 1'b1;
         scanResetN_q <= scanStage_q;
      end
   end

   assign auxScanClk    = scanClk_q;
   assign auxScanResetN = scanResetN_q;
   // ==========================================================
   // phy reset sequencing
   ddr_phy_pkg::phy_state_t phyState_q;
   logic [3:0]              holdCount_q;
   logic                    ctlResetN_q;

   // soft edge wins over everything; lock loss parks the phy
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phyState_q  <= ddr_phy_pkg::PHY_HOLD;
         holdCount_q <= 4'(ddr_phy_pkg::SOFT_HOLD_CYCLES);
      end else if (softFall) begin
         phyState_q  <= ddr_phy_pkg::PHY_HOLD;
         holdCount_q <= 4'(ddr_phy_pkg::SOFT_HOLD_CYCLES);
      end else begin
         unique case (phyState_q)
            ddr_phy_pkg::PHY_HOLD: begin
               if (holdCount_q == 4'h0) begin
                  phyState_q <= ddr_phy_pkg::PHY_WAIT_LOCK;
               end else begin
                  holdCount_q <= holdCount_q - 4'h1;
               end
            end
            ddr_phy_pkg::PHY_WAIT_LOCK: begin
               if (pllLocked_q) begin
                  phyState_q <= ddr_phy_pkg::PHY_RUN;
               end
            end
            ddr_phy_pkg::PHY_RUN: begin
               if (!pllLocked_q) begin
                  phyState_q <= ddr_phy_pkg::PHY_WAIT_LOCK;
               end
            end
            default: begin
               phyState_q <= ddr_phy_pkg::PHY_HOLD;
            end
         endcase
      end
   end

   // drops at once, rises only with a controller clock edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctlResetN_q <= 1'b0;
      end else if (phyState_q != ddr_phy_pkg::PHY_RUN) begin
         ctlResetN_q <= 1'b0;
      end else if (ctlTick) begin
         ctlResetN_q <= 1'b1;
      end
   end

   assign ctlResetN = ctlResetN_q;
   // ==========================================================
   // write buffer; drain stalls while the phy is held
   ddr_phy_pkg::write_word_t fifoOut;
   logic                     fifoOutValid;
   logic                     fifoPush;
   logic                     fifoPop;

   // idle words are not stored, so a gap costs no buffer space
   assign fifoPush = ctlTick & ((|ctlWrite.writeValid) | (|ctlWrite.dqsBurst));
   assign fifoPop  = ctlTick & (phyState_q == ddr_phy_pkg::PHY_RUN);

   write_fifo #(
      .WIDTH ($bits(ddr_phy_pkg::write_word_t)),
      .DEPTH (ddr_phy_pkg::FIFO_DEPTH)
   ) writeBuffer (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .inValid  (fifoPush),
      .inData   (ctlWrite),
      .inReady  (ctlWriteReady),
      .outValid (fifoOutValid),
      .outData  (fifoOut),
      .outReady (fifoPop)
   );
   // ==========================================================
   // serialiser: one word over four beats
   ddr_phy_pkg::write_word_t curWord_q;
   logic                     wordLive_q;
   ddr_phy_pkg::write_pins_t pins_q;

   // load at the controller tick, then play beats 0..3
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         curWord_q  <= '0;
         wordLive_q <= 1'b0;
      end else if (fifoPop) begin
         curWord_q  <= fifoOut;
         wordLive_q <= fifoOutValid;
      end
   end

   // pins follow the beat; each half has its own valid and burst bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pins_q <= '{dq: '0, dqOeN: '1, dm: '0, dmOeN: '1, dqs: '0, dqsN: '1, dqsOeN: '1};
      end else begin
         pins_q.dq     <= curWord_q.writeData[phase_q*DW +: DW];
         pins_q.dm     <= curWord_q.controllerWriteMask[phase_q*MW +: MW];
         pins_q.dqOeN  <= {DW{~(wordLive_q & curWord_q.writeValid[phase_q[1]])}};
         pins_q.dmOeN  <= {MW{~(wordLive_q & curWord_q.writeValid[phase_q[1]])}};
         pins_q.dqsOeN <= ~(wordLive_q & curWord_q.dqsBurst[phase_q[1]]);
         pins_q.dqs    <= ~phase_q[0];
         pins_q.dqsN   <= phase_q[0];
      end
   end

   assign memWrite = pins_q;
   // ==========================================================
   // parity for registered modules only
   logic parityOut_q;
   logic parityErrN_q;

   // parity of each command word; error flag sticky until phy reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         parityOut_q  <= 1'b0;
         parityErrN_q <= 1'b1;
      end else begin
         if (ctlTick) begin
            parityOut_q <= ddr_phy_pkg::REGISTERED_DIMM & (^controllerCommand);
         end
         if (ddr_phy_pkg::REGISTERED_DIMM && !errSync_q[1]) begin
            parityErrN_q <= 1'b0;   // set beats the clear
         end else if (phyState_q == ddr_phy_pkg::PHY_HOLD) begin
            parityErrN_q <= 1'b1;
         end
      end
   end

   assign commandParityOut = parityOut_q;
   assign parityErrorN     = parityErrN_q;
   // ==========================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_ctl_reset_locked: assert property ($rose(ctlResetN_q) |-> resetRequestN)
      else $error("controller reset released without lock");
   a_ctl_release_tick: assert property ($rose(ctlResetN_q) |-> $past(ctlTick) && ctlClk_q)
      else $error("controller reset released off a clock edge");
   a_soft_holds_phy: assert property (softFall |=> phyState_q == ddr_phy_pkg::PHY_HOLD ##1 !ctlResetN_q)
      else $error("soft reset edge did not reset the phy");
   a_soft_keeps_lock: assert property (softFall && pllLocked_q && refIdle_q < 7'h3c |=> pllLocked_q)
      else $error("soft reset disturbed lock");
   a_request_while_locking: assert property (!pllLocked_q && !refRise |=> !resetRequestN)
      else $error("reset request high before lock");
   a_half_clock_copy: assert property (auxHalfRateClk == ctlClk && $changed(ctlClk) |=> $stable(ctlClk) ##1 $changed(ctlClk))
      else $error("half-rate clock copy wrong");
   a_scan_release_edge: assert property ($rose(scanResetN_q) |-> $past(scanRise))
      else $error("scan reset released off scan edge");
   a_burst_drives_strobe: assert property (wordLive_q && curWord_q.dqsBurst[phase_q[1]] |=> !pins_q.dqsOeN)
      else $error("strobe not driven during burst");
   a_valid_enables_data: assert property (wordLive_q && !curWord_q.writeValid[phase_q[1]] |=> &pins_q.dqOeN)
      else $error("data driven without write valid");
   a_data_beat_order: assert property (phase_q == 2'h1 |=> pins_q.dq == $past(curWord_q.writeData[DW +: DW]))
      else $error("write beat out of order");
   a_parity_value: assert property (ctlTick |=> commandParityOut == (^$past(controllerCommand)))
      else $error("command parity wrong");
   c_lock_reached: cover property ($rose(pllLocked_q));
   c_buffer_full: cover property (!ctlWriteReady);
   c_soft_when_running: cover property (softFall && phyState_q == ddr_phy_pkg::PHY_RUN);
   c_strobe_burst: cover property (!pins_q.dqsOeN ##1 !pins_q.dqOeN[0]);
endmodule // ddr_phy_clock_reset_write_port

// >>> logic/ddr_phy_pkg.sv
package ddr_phy_pkg;

   // ==========================================================
   // widths
   localparam int MEMORY_DATA_WIDTH = 8;     // data pins
   localparam int MEMORY_MASK_WIDTH = 1;     // mask pins
   localparam int DQS_GROUPS        = 1;     // strobe groups
   localparam int RATE_RATIO        = 4;     // data beats per controller cycle
   localparam int HALF_RATIO        = RATE_RATIO / 2;
   localparam int COMMAND_BITS      = 24;    // address/command bits covered by parity
   localparam int FIFO_DEPTH        = 32;    // write buffer words

   // ==========================================================
   // timing counts, in system clock cycles except LOCK_EDGES, which counts reference edges
   localparam int LOCK_EDGES        = 16;    // reference edges before lock
   localparam int LOCK_LOSS_CYCLES  = 64;    // reference silence that drops lock
   localparam int SOFT_HOLD_CYCLES  = 8;     // phy hold after a soft reset edge
   localparam int SCAN_HALF_CYCLES  = 8;     // scan clock half period

   // ==========================================================
   // options and reset values
   localparam bit REGISTERED_DIMM   = 1'b1;  // parity pins in use
   localparam logic [1:0] PHASE_RESET = 2'h0;

   // one controller-cycle write word, carried through the buffer
   typedef struct packed {
      logic [DQS_GROUPS*HALF_RATIO-1:0]          dqsBurst;
      logic [DQS_GROUPS*HALF_RATIO-1:0]          writeValid;
      logic [MEMORY_MASK_WIDTH*RATE_RATIO-1:0]   controllerWriteMask;
      logic [MEMORY_DATA_WIDTH*RATE_RATIO-1:0]   writeData;
   } write_word_t;

   // memory-side write pins for one beat; enables are active low
   typedef struct packed {
      logic [MEMORY_DATA_WIDTH-1:0] dq;
      logic [MEMORY_DATA_WIDTH-1:0] dqOeN;
      logic [MEMORY_MASK_WIDTH-1:0] dm;
      logic [MEMORY_MASK_WIDTH-1:0] dmOeN;
      logic [DQS_GROUPS-1:0]        dqs;
      logic [DQS_GROUPS-1:0]        dqsN;
      logic [DQS_GROUPS-1:0]        dqsOeN;
   } write_pins_t;

   typedef enum logic [1:0] {
      PHY_HOLD      = 2'b00,
      PHY_WAIT_LOCK = 2'b01,
      PHY_RUN       = 2'b10
   } phy_state_t;

endpackage

// >>> dv/ctl_write_source.sv
// ==========================================================
// controller-side write source, one word per half-rate cycle
module ctl_write_source (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               ctlClk,
   input  wire logic               ctlWriteReady,
   input  wire logic               sendEn,
   output ddr_phy_pkg::write_word_t ctlWrite,
   output logic [7:0]              taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       lastClk;  // controller clock one edge ago
   logic       started;  // burst already opened for this write
   logic       accepted; // the data word at this tick was stored
   logic [7:0] nextIdx;  // index of the next data word
   // ==========================================================
   // words change only just after a tick; a refused word is sent again
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lastClk <= 1'b0;
         started <= 1'b0;
         taken <= 8'h00;
         ctlWrite <= '0;
      end else begin
         lastClk <= ctlClk;
         // tick: the edge that closes a controller cycle
         if (!ctlClk && !lastClk) begin
            accepted = ctlWriteReady && (ctlWrite.writeValid != '0);
            nextIdx = taken + {7'h00, accepted};
            taken <= nextIdx;
            started <= sendEn;
            if (sendEn && started) begin
               ctlWrite <= '{dqsBurst: '1, writeValid: '1, controllerWriteMask: 4'h5,
                  writeData: {nextIdx[5:0], 2'h3, nextIdx[5:0], 2'h2, nextIdx[5:0], 2'h1, nextIdx[5:0], 2'h0}};
            end else begin
               // burst alone opens a write a cycle before valid, and drops with the last word
               ctlWrite <= '{dqsBurst: {2{sendEn}}, writeValid: 2'h0, controllerWriteMask: 4'h0, writeData: 32'h0};
            end
         end
      end
   end
endmodule // ctl_write_source

// >>> dv/test_ddr_phy_clock_reset_write_port.sv
// ==========================================================
// top of the bench: clocks, partner, monitor, scenarios
module test_ddr_phy_clock_reset_write_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic pllRefClk = 1'b0;
   logic softResetN = 1'b1;
   logic refOn = 1'b0;         // reference clock gate
   logic sendEn = 1'b0;        // partner writes while high
   logic [23:0] controllerCommand = 24'h000000;
   logic memErrOutN = 1'b1;
   logic resetRequestN, ctlClk, ctlResetN, auxHalfRateClk, auxFullRateClk, auxScanClk, auxScanResetN;
   logic ctlWriteReady, memClk, memClkN, memClkOeN, clockFeedbackSeen, commandParityOut, parityErrorN;
   logic [7:0] taken;          // data words the design accepted
   logic [7:0] expByte = 8'h00; // next byte due on the data pins
   int failures = 0;
   int checked = 0;
   logic lastReq = 1'b0;       // reset request one edge ago
   int reqFalls = 0;           // falling edges of the reset request
   ddr_phy_pkg::write_word_t ctlWrite;
   ddr_phy_pkg::write_pins_t memWrite;
   always #4 clk_sys = ~clk_sys;
   // reference clock only runs while gated on; stopping it drops lock
   always @(posedge clk_sys) if (refOn) pllRefClk <= ~pllRefClk;
   ddr_phy_clock_reset_write_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pllRefClk(pllRefClk),
      .softResetN(softResetN), .resetRequestN(resetRequestN), .ctlClk(ctlClk), .ctlResetN(ctlResetN),
      .auxHalfRateClk(auxHalfRateClk), .auxFullRateClk(auxFullRateClk), .auxScanClk(auxScanClk),
      .auxScanResetN(auxScanResetN), .ctlWrite(ctlWrite), .ctlWriteReady(ctlWriteReady),
      .controllerCommand(controllerCommand), .memWrite(memWrite), .memClk(memClk), .memClkN(memClkN),
      .memClkOeN(memClkOeN), .memClkIn(memClk), .clockFeedbackSeen(clockFeedbackSeen),
      .commandParityOut(commandParityOut), .parityErrorN(parityErrorN), .memErrOutN(memErrOutN));
   ctl_write_source u_src (.clk_sys(clk_sys), .rst_n(rst_n), .ctlClk(ctlClk), .ctlWriteReady(ctlWriteReady),
      .sendEn(sendEn), .ctlWrite(ctlWrite), .taken(taken));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // monitor: driven beats come out in byte order, mask follows
   always @(posedge clk_sys) begin
      if (!rst_n) expByte <= 8'h00;
      else if (memWrite.dqOeN === 8'h00) begin
         check("dq", memWrite.dq, expByte);
         check("dm", memWrite.dm, !expByte[0]);
         check("dm enable", memWrite.dmOeN, 1'b0);
         check("strobe enable", memWrite.dqsOeN, 1'b0);
         check("strobe", {memWrite.dqs, memWrite.dqsN}, {~expByte[0], expByte[0]});
         expByte <= expByte + 8'h01;
      end
   end
   // outside reset logic acts on the falling edge of the request, not its level
   always @(posedge clk_sys) begin
      lastReq <= resetRequestN;
      if (lastReq === 1'b1 && resetRequestN === 1'b0) reqFalls <= reqFalls + 1;
   end
   // stream for some ticks, let the buffer drain, compare totals
   task automatic t_write(input int ticks);
      sendEn <= (ticks > 0);
      repeat (4 * ticks) @(posedge clk_sys);
      if (ticks > 0) sendEn <= 1'b0;
      for (int i = 0; i < 400 && expByte !== {taken[5:0], 2'b00}; i++) @(posedge clk_sys);
      repeat (30) @(posedge clk_sys);
      check("bytes", expByte, {taken[5:0], 2'b00});
   endtask
   // ==========================================================
   // fill before lock, then lock and drain
   task automatic t_fill_lock();
      sendEn <= 1'b1;
      repeat (160) @(posedge clk_sys);
      check("ready full", ctlWriteReady, 1'b0);
      check("no lock", resetRequestN, 1'b0);
      sendEn <= 1'b0;
      refOn <= 1'b1;
      for (int i = 0; i < 200 && resetRequestN !== 1'b1; i++) @(posedge clk_sys);
      check("locked", resetRequestN, 1'b1);
      for (int i = 0; i < 200 && ctlResetN !== 1'b1; i++) @(posedge clk_sys);
      check("ctl reset off", ctlResetN, 1'b1);
      t_write(0);
      check("words held", taken, 8'(ddr_phy_pkg::FIFO_DEPTH - 1));
   endtask
   task automatic t_clocks();
      int halfRises = 0;
      int scanRises = 0;
      logic prevHalf = ctlClk;
      logic prevScan = auxScanClk;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_sys);
         check("aux half", auxHalfRateClk, ctlClk);
         check("aux full", auxFullRateClk, memClk);
         check("clk pair", {memClkN, memClkOeN}, {~memClk, 1'b0});
         halfRises += int'(ctlClk && !prevHalf);
         scanRises += int'(auxScanClk && !prevScan);
         prevHalf = ctlClk;
         prevScan = auxScanClk;
      end
      check("half rises", halfRises, 16);
      check("scan rises", scanRises, 4);
      check("feedback", clockFeedbackSeen, 1'b1);
   endtask
   // parity out and sticky error flag
   task automatic t_parity();
      controllerCommand <= 24'h000007;
      repeat (12) @(posedge clk_sys);
      check("parity odd", commandParityOut, 1'b1);
      controllerCommand <= 24'h000003;
      memErrOutN <= 1'b0;
      repeat (4) @(posedge clk_sys);
      memErrOutN <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check("parity even", commandParityOut, 1'b0);
      check("error flag", parityErrorN, 1'b0);
   endtask
   // soft reset: phy restarts, lock untouched, flag cleared
   task automatic t_soft();
      softResetN <= 1'b0;
      repeat (2) @(posedge clk_sys);
      softResetN <= 1'b1;
      for (int i = 0; i < 20 && ctlResetN !== 1'b0; i++) @(posedge clk_sys);
      check("soft hold", ctlResetN, 1'b0);
      check("lock kept", resetRequestN, 1'b1);
      for (int i = 0; i < 100 && ctlResetN !== 1'b1; i++) @(posedge clk_sys);
      check("soft done", {ctlResetN, parityErrorN}, 2'b11);
   endtask
   // lock loss, then global reset in mid-run
   task automatic t_loss_global();
      refOn <= 1'b0;
      for (int i = 0; i < 150 && resetRequestN !== 1'b0; i++) @(posedge clk_sys);
      check("lock lost", resetRequestN, 1'b0);
      refOn <= 1'b1;
      @(posedge clk_sys);
      check("request edge", reqFalls, 1);
      rst_n <= 1'b0;
      #1;
      check("async resets", {auxScanResetN, ctlResetN, resetRequestN}, 3'b000);
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 100 && auxScanResetN !== 1'b1; i++) @(posedge clk_sys);
      check("scan release", {auxScanResetN, auxScanClk}, 2'b11);
   endtask
   // ==========================================================
   // watchdog, sized well above the scenario run
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      check("reset outs", {resetRequestN, ctlResetN, auxScanResetN, memWrite.dqOeN}, 11'h0ff);
      rst_n <= 1'b1;
      t_fill_lock();
      t_clocks();
      t_write(10);
      t_parity();
      t_soft();
      t_loss_global();
      close_out();
   end
endmodule // test_ddr_phy_clock_reset_write_port
